/* hdl/tbx_pkg.sv */
// constants for the 10 Mb control and self-test extension register bank
package tbx_pkg;

  // ==========================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_SELFTEST_CTL = 8'h19;
  localparam logic [7:0] IDX_TENBASE = 8'h1a;
  localparam logic [7:0] IDX_PATTERN_EXT = 8'h1b;
  localparam logic [7:0] ADDR_SELFTEST_CTL = {IDX_SELFTEST_CTL[5:0], 2'h0};
  localparam logic [7:0] ADDR_TENBASE = {IDX_TENBASE[5:0], 2'h0};
  localparam logic [7:0] ADDR_PATTERN_EXT = {IDX_PATTERN_EXT[5:0], 2'h0};

  // ==========================================
  // tenbase_status_control fields
  localparam int TB_SQL_LSB = 9;
  localparam int TB_ECHO_DIS = 8;
  localparam int TB_NLP_OFF = 7;
  localparam int TB_FORCE_LINK = 6;
  localparam int TB_POLARITY = 4;
  localparam int TB_SQE_OFF = 1;
  localparam int TB_GUARD_OFF = 0;
  localparam logic [15:0] TB_RESET = 16'h0804;
  localparam logic [15:0] TB_RW_MASK = 16'hffef;

  // ==========================================
  // pattern_test_selftest_ext fields
  localparam int PX_CNT_LSB = 8;
  localparam int PX_CONT = 5;
  localparam int PX_PAT_EN = 4;
  localparam int PX_GAP = 2;
  localparam int PX_SEL_LSB = 0;
  localparam logic [7:0] PX_RESET = 8'h00;
  localparam logic [7:0] ERR_CNT_MAX = 8'hff;
  localparam logic [1:0] SEL_MANCH_ONES = 2'h3;

  // ==========================================
  // self-test control register
  localparam int SC_RUN = 8;

  // ==========================================
  // pattern gap timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAP_LONG_US = 15;
  localparam int GAP_SHORT_US = 10;
  localparam logic [7:0] GAP_LONG_CYC = 8'(GAP_LONG_US * 1000 / CLK_PERIOD_NS);
  localparam logic [7:0] GAP_SHORT_CYC = 8'(GAP_SHORT_US * 1000 / CLK_PERIOD_NS);

endpackage

/* hdl/tbx_regs.sv */
// 10 Mb status/control and self-test extension registers behind AXI4-Lite
// ==========================================
// Notes on behaviour
// RULE1: three-bit squelch field, resets to 100
// RULE2: half-duplex 10 Mb echo unless disabled
// RULE3: echo disable leaves basic loopback alone
// RULE4: link pulse off bit stops link pulses
// RULE5: forced link bit reports good link
// RULE6: polarity latches high, clears on read
// RULE7: heartbeat only in half-duplex 10 Mb
// RULE8: long-transmit guard off only at 10 Mb
// RULE9: software keeps reserved bits at documented values
// RULE10: count errored nibbles while self-test runs
// RULE11: counter clears when self-test restarts
// RULE12: counter saturates at maximum
// RULE13: continuous mode sends gapless pseudo-random data
// RULE14: software disables guard before continuous mode
// RULE15: pattern enable bit gates test pattern
// RULE16: two-bit select picks pattern kind
// RULE17: gap bit picks 15 or 10 us
// RULE18: self-test runs while run bit set
// RULE19: read-only fields ignore writes
// RULE20: polarity read first, cleared after read
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module tbx_regs
  import tbx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // line and mode status from the datapath
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic line_link_ok_i,
  input wire logic polarity_inverted_i,
  input wire logic basic_loopback_i,
  input wire logic selftest_nibble_err_i,
  // controls to the 10 Mb datapath
  output logic [2:0] squelch_level_o,
  output logic rx_echo_en_o,
  output logic loopback_o,
  output logic link_pulse_tx_en_o,
  output logic link_good_o,
  output logic sqe_heartbeat_en_o,
  output logic long_tx_guard_en_o,
  output logic polarity_status_o,
  // self-test and test pattern controls
  output logic selftest_run_o,
  output logic selftest_continuous_o,
  output logic slow_test_pattern_enable_o,
  output logic [1:0] slow_test_pattern_select_o,
  output logic test_seq_start_o
);

  // ==========================================
  // state
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic aw_held; // write address captured
    logic [ADDR_W-1:0] awaddr;
    logic w_held; // write data captured
    logic [REG_W-1:0] wdata;
    logic [1:0] wstrb;
    logic rd_clr; // pending polarity clear after read
    logic [REG_W-1:0] tb; // tenbase_status_control storage
    logic [7:0] px; // writable half of pattern_test_selftest_ext
    logic [7:0] err_cnt; // self-test error counter
    logic run; // self-test run bit
    logic run_d; // run bit one cycle back
    logic pol; // latched polarity
    logic [2:0] sql;
    logic echo;
    logic loop;
    logic nlp;
    logic link;
    logic hb;
    logic jab;
    logic pat_start; // one-cycle pattern sequence start
    logic [7:0] gap_cnt; // cycles left in current gap
  } tbx_state_t;

  tbx_state_t st_r;
  tbx_state_t st_nxt;

  // ==========================================
  // helpers
  // byte-lane merge of a write into writable bits only
  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
    input logic [REG_W-1:0] wd, input logic [1:0] strb, input logic [REG_W-1:0] rw_mask);
    logic [REG_W-1:0] lane;
    lane = {{8{strb[1]}}, {8{strb[0]}}} & rw_mask;
    return (old & ~lane) | (wd & lane);
  endfunction

  // address decode: one when the address hits a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_TENBASE) || (a == ADDR_PATTERN_EXT) || (a == ADDR_SELFTEST_CTL);
  endfunction

  logic run_rise; // self-test restarted
  logic do_write; // both write halves present
  assign run_rise = st_r.run & ~st_r.run_d;
  assign do_write = st_r.aw_held & st_r.w_held & ~st_r.bvalid;

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pat_start = 1'b0;
    // write address and data are taken independently
    if (s_axi_awvalid_i && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata_i[REG_W-1:0];
      st_nxt.wstrb = s_axi_wstrb_i[1:0];
    end

    // perform write once both halves are in
    if (do_write) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = is_mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st_r.awaddr)
        // polarity bit is masked out of the write
        ADDR_TENBASE: begin
          st_nxt.tb = merge16(st_r.tb, st_r.wdata, st_r.wstrb, TB_RW_MASK); // RULE19
        end
        // upper byte is the counter, never written
        ADDR_PATTERN_EXT: begin
          if (st_r.wstrb[0]) begin
            st_nxt.px = st_r.wdata[7:0]; // RULE19
          end
        end
        ADDR_SELFTEST_CTL: begin
          if (st_r.wstrb[1]) begin
            st_nxt.run = st_r.wdata[SC_RUN]; // RULE18
          end
        end
        default: ;
      endcase
    end else if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end
    st_nxt.awready = ~st_nxt.aw_held & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_held & ~st_nxt.bvalid;
    // read: data captured at address acceptance, latch cleared later
    if (s_axi_arvalid_i && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata = '0;
      st_nxt.rd_clr = 1'b0;
      unique case (s_axi_araddr_i)
        ADDR_TENBASE: begin
          st_nxt.rdata[REG_W-1:0] = st_r.tb | (REG_W'({st_r.pol}) << TB_POLARITY); // RULE20
          st_nxt.rd_clr = 1'b1;
        end
        ADDR_PATTERN_EXT: begin
          st_nxt.rdata[REG_W-1:0] = {st_r.err_cnt, st_r.px};
        end
        ADDR_SELFTEST_CTL: begin
          st_nxt.rdata[REG_W-1:0] = REG_W'({st_r.run}) << SC_RUN; // RULE18
        end
        default: ;
      endcase
    end else if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.rd_clr = 1'b0;
    end
    st_nxt.arready = ~st_nxt.rvalid;
    // polarity latch: clear after read completes, a new event wins
    if (st_r.rvalid && s_axi_rready_i && st_r.rd_clr) begin
      st_nxt.pol = 1'b0; // RULE6
    end
    // an event the captured data missed cancels the pending clear
    if (polarity_inverted_i) begin
      st_nxt.pol = 1'b1; // RULE6
      st_nxt.rd_clr = 1'b0; // RULE20
    end

    // self-test error counter
    st_nxt.run_d = st_r.run;
    if (run_rise) begin
      st_nxt.err_cnt = '0; // RULE11
    end else if (st_r.run && selftest_nibble_err_i && st_r.err_cnt != ERR_CNT_MAX) begin
      st_nxt.err_cnt = st_r.err_cnt + 8'h01; // RULE10 RULE12
    end

    // datapath controls
    st_nxt.sql = st_r.tb[TB_SQL_LSB +: 3]; // RULE1
    st_nxt.echo = ~speed_100_i & ~full_duplex_i & ~st_r.tb[TB_ECHO_DIS]; // RULE2
    st_nxt.loop = basic_loopback_i; // RULE3
    st_nxt.nlp = ~st_r.tb[TB_NLP_OFF]; // RULE4
    st_nxt.link = st_r.tb[TB_FORCE_LINK] | line_link_ok_i; // RULE5
    st_nxt.hb = ~speed_100_i & ~full_duplex_i & ~st_r.tb[TB_SQE_OFF]; // RULE7
    st_nxt.jab = speed_100_i | ~st_r.tb[TB_GUARD_OFF]; // RULE8

    // test sequence spacing for data and link pulse patterns
    if (st_r.px[PX_PAT_EN] && st_r.px[PX_SEL_LSB +: 2] != SEL_MANCH_ONES) begin
      if (st_r.gap_cnt == 8'h00) begin
        st_nxt.pat_start = 1'b1; // RULE16
        st_nxt.gap_cnt = (st_r.px[PX_GAP] ? GAP_LONG_CYC : GAP_SHORT_CYC) - 8'h01; // RULE17
      end else begin
        st_nxt.gap_cnt = st_r.gap_cnt - 8'h01;
      end
    end else begin
      st_nxt.gap_cnt = 8'h00; // RULE15
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
      st_r.tb <= TB_RESET;
      st_r.px <= PX_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  assign s_axi_awready_o = st_r.awready;
  assign s_axi_wready_o = st_r.wready;
  assign s_axi_bvalid_o = st_r.bvalid;
  assign s_axi_bresp_o = st_r.bresp;
  assign s_axi_arready_o = st_r.arready;
  assign s_axi_rvalid_o = st_r.rvalid;
  assign s_axi_rresp_o = st_r.rresp;
  assign s_axi_rdata_o = st_r.rdata;
  assign squelch_level_o = st_r.sql;
  assign rx_echo_en_o = st_r.echo;
  assign loopback_o = st_r.loop;
  assign link_pulse_tx_en_o = st_r.nlp;
  assign link_good_o = st_r.link;
  assign sqe_heartbeat_en_o = st_r.hb;
  assign long_tx_guard_en_o = st_r.jab;
  assign polarity_status_o = st_r.pol; // RULE6
  assign selftest_run_o = st_r.run; // RULE18
  assign selftest_continuous_o = st_r.px[PX_CONT]; // RULE13
  assign slow_test_pattern_enable_o = st_r.px[PX_PAT_EN]; // RULE15
  assign slow_test_pattern_select_o = st_r.px[PX_SEL_LSB +: 2]; // RULE16
  assign test_seq_start_o = st_r.pat_start;

  // ==========================================
  // assertions
  property p_squelch_follows;
    @(posedge clk_i) disable iff (!nrst_i)
    s_axi_wvalid_i |-> ##2 squelch_level_o == $past(st_r.tb[TB_SQL_LSB +: 3], 1);
  endproperty
  a_squelch_follows: assert property (p_squelch_follows) // RULE1
    else $error("squelch output lags its field");

  property p_echo_off_full_duplex;
    @(posedge clk_i) disable iff (!nrst_i)
    full_duplex_i |=> !rx_echo_en_o;
  endproperty
  a_echo_off_full_duplex: assert property (p_echo_off_full_duplex) // RULE2
    else $error("echo enabled in full duplex");

  property p_loop_independent;
    @(posedge clk_i) disable iff (!nrst_i)
    (basic_loopback_i && st_r.tb[TB_ECHO_DIS]) |=> loopback_o;
  endproperty
  a_loop_independent: assert property (p_loop_independent) // RULE3
    else $error("echo disable blocked basic loopback");

  property p_link_forced;
    @(posedge clk_i) disable iff (!nrst_i)
    st_r.tb[TB_FORCE_LINK] |=> link_good_o;
  endproperty
  a_link_forced: assert property (p_link_forced) // RULE5
    else $error("forced link not reported");

  property p_pol_set_wins;
    @(posedge clk_i) disable iff (!nrst_i)
    polarity_inverted_i |=> polarity_status_o;
  endproperty
  a_pol_set_wins: assert property (p_pol_set_wins) // RULE6
    else $error("polarity event lost");

  property p_hb_off_fast;
    @(posedge clk_i) disable iff (!nrst_i)
    speed_100_i |=> !sqe_heartbeat_en_o;
  endproperty
  a_hb_off_fast: assert property (p_hb_off_fast) // RULE7
    else $error("heartbeat active at 100 Mb");

  property p_guard_fast;
    @(posedge clk_i) disable iff (!nrst_i)
    speed_100_i |=> long_tx_guard_en_o;
  endproperty
  a_guard_fast: assert property (p_guard_fast) // RULE8
    else $error("guard disable acted at 100 Mb");

  property p_cnt_step;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_r.run && !run_rise && selftest_nibble_err_i && st_r.err_cnt != ERR_CNT_MAX)
      |=> st_r.err_cnt == $past(st_r.err_cnt) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) // RULE10
    else $error("error counter missed a nibble");

  property p_cnt_restart;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(selftest_run_o) |=> st_r.err_cnt == 8'h00;
  endproperty
  a_cnt_restart: assert property (p_cnt_restart) // RULE11
    else $error("error counter not cleared on restart");

  property p_cnt_sat;
    @(posedge clk_i) disable iff (!nrst_i)
    (st_r.err_cnt == ERR_CNT_MAX && !run_rise) |=> st_r.err_cnt == ERR_CNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) // RULE12
    else $error("error counter wrapped");

  property p_gap_spacing;
    @(posedge clk_i) disable iff (!nrst_i)
    test_seq_start_o |=> !test_seq_start_o [*8];
  endproperty
  a_gap_spacing: assert property (p_gap_spacing) // RULE17
    else $error("pattern sequences too close");

  property p_ro_counter;
    @(posedge clk_i) disable iff (!nrst_i)
    (!st_r.run && !selftest_nibble_err_i) |=> $stable(st_r.err_cnt);
  endproperty
  a_ro_counter: assert property (p_ro_counter) // RULE19
    else $error("counter changed without self-test");

endmodule

`default_nettype wire

/* dv/tb_tbx_regs.sv */
// self-checking bench for the 10 Mb control and self-test extension registers
`timescale 1ns/100ps
`default_nettype none

module tb_tbx_regs;
  import tbx_pkg::*;

  // ==========================================
  // clock, reset, bus and datapath signals
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [3:0] strb_sel = 4'hf; // byte lanes used by the next write
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, psel;
  logic spd = 0, fdx = 0, lnk = 0, pol = 0, lbk = 0, nerr = 0;
  logic [2:0] sql;
  logic echo, lbo, nlp, lgood, hb, guard, pst, run, cont, paten, seq;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  int n;

  tbx_regs DUT (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .speed_100_i(spd),
    .full_duplex_i(fdx), .line_link_ok_i(lnk), .polarity_inverted_i(pol),
    .basic_loopback_i(lbk), .selftest_nibble_err_i(nerr), .squelch_level_o(sql),
    .rx_echo_en_o(echo), .loopback_o(lbo), .link_pulse_tx_en_o(nlp),
    .link_good_o(lgood), .sqe_heartbeat_en_o(hb), .long_tx_guard_en_o(guard),
    .polarity_status_o(pst), .selftest_run_o(run), .selftest_continuous_o(cont),
    .slow_test_pattern_enable_o(paten), .slow_test_pattern_select_o(psel),
    .test_seq_start_o(seq));

  // ==========================================
  // clock, watchdog and helpers
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // cut a hang short well past the expected run length
  initial begin
    #3_000_000;
    fail_count++;
    conclude();
  end

  task automatic conclude();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // axi4-lite write: address and data offered together, held until taken
  // an idle edge first keeps back-to-back calls from re-driving a released signal
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb_sel;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read: address held until taken, rready until data seen
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // write then let the registered controls settle
  task automatic wset(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk(32'(rs), 32'(RESP_OKAY));
    tick(2);
  endtask

  // skip one sequence start, then count edges to the next one
  task automatic gap(output int c);
    repeat (2) begin
      c = 0;
      do begin
        @(posedge clk_i);
        c++;
      end while (!seq && c < 400);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0804);
    chk(32'(sql), 32'h0000_0004);
    chk(32'({echo, nlp, hb, guard}), 32'h0000_000f);
    rdr(ADDR_PATTERN_EXT, rd, rs);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic t_tenbase();
    lbk <= 1'b1;
    wset(ADDR_TENBASE, 32'h0000_ffff);
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_ffef);
    chk(32'(sql), 32'h0000_0007);
    chk(32'({echo, nlp, lgood, hb, guard, lbo}), 32'h0000_0009);
    wset(ADDR_TENBASE, 32'h0000_0804);
    chk(32'({echo, nlp, lgood, lbo}), 32'h0000_000d);
    lnk <= 1'b1;
    tick(2);
    chk(32'(lgood), 32'h0000_0001);
    lnk <= 1'b0;
    fdx <= 1'b1;
    tick(2);
    chk(32'({echo, hb}), 32'h0000_0000);
    fdx <= 1'b0;
    spd <= 1'b1;
    wset(ADDR_TENBASE, 32'h0000_0805);
    chk(32'({hb, guard}), 32'h0000_0001);
    spd <= 1'b0;
    tick(2);
    chk(32'({hb, guard}), 32'h0000_0002);
    wset(ADDR_TENBASE, 32'h0000_0804);
    lbk <= 1'b0;
  endtask

  task automatic t_polarity();
    pol <= 1'b1;
    tick(1);
    pol <= 1'b0;
    tick(2);
    chk(32'(pst), 32'h0000_0001);
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0814);
    tick(2);
    chk(32'(pst), 32'h0000_0000);
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0804);
    // event lands in the cycle the read data is captured: it must survive
    fork
      rdr(ADDR_TENBASE, rd, rs);
      begin
        tick(1);
        pol <= 1'b1;
        tick(1);
        pol <= 1'b0;
      end
    join
    chk(rd, 32'h0000_0804);
    tick(2);
    chk(32'(pst), 32'h0000_0001);
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0814);
    tick(2);
    chk(32'(pst), 32'h0000_0000);
  endtask

  task automatic t_selftest();
    wset(ADDR_SELFTEST_CTL, 32'h0000_0100);
    chk(32'(run), 32'h0000_0001);
    nerr <= 1'b1;
    tick(3);
    nerr <= 1'b0;
    tick(2);
    rdr(ADDR_PATTERN_EXT, rd, rs);
    chk(rd, 32'h0000_0300);
    nerr <= 1'b1;
    tick(260);
    nerr <= 1'b0;
    tick(2);
    rdr(ADDR_PATTERN_EXT, rd, rs);
    chk(rd, 32'h0000_ff00);
    wset(ADDR_SELFTEST_CTL, 32'h0000_0000);
    wset(ADDR_SELFTEST_CTL, 32'h0000_0100);
    rdr(ADDR_PATTERN_EXT, rd, rs);
    chk(rd, 32'h0000_0000);
    wset(ADDR_SELFTEST_CTL, 32'h0000_0000);
  endtask

  task automatic t_pattern();
    // guard off before continuous mode, as software must
    wset(ADDR_TENBASE, 32'h0000_0805);
    wset(ADDR_PATTERN_EXT, 32'h0000_ff30);
    rdr(ADDR_PATTERN_EXT, rd, rs);
    chk(rd, 32'h0000_0030);
    chk(32'({cont, paten}), 32'h0000_0003);
    gap(n);
    chk(32'(n), 32'(GAP_SHORT_CYC));
    wset(ADDR_PATTERN_EXT, 32'h0000_0014);
    gap(n);
    chk(32'(n), 32'(GAP_LONG_CYC));
    // every select that runs timed sequences, then SEL_MANCH_ONES, which starts none
    for (int s = 0; s < 4; s++) begin
      wset(ADDR_PATTERN_EXT, 32'h0000_0010 | 32'(s));
      chk(32'(psel), 32'(s));
      if (s < 3) begin
        gap(n);
        chk(32'(n), 32'(GAP_SHORT_CYC));
      end
    end
    gap(n);
    chk(32'(n), 32'd400);
    wset(ADDR_PATTERN_EXT, 32'h0000_0000);
    chk(32'(paten), 32'h0000_0000);
    gap(n);
    chk(32'(n), 32'd400);
    wset(ADDR_TENBASE, 32'h0000_0804);
  endtask

  task automatic t_unmapped();
    wr(8'h70, 32'h0000_ffff, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    rdr(8'h70, rd, rs);
    chk({rd[29:0], rs}, 32'(RESP_SLVERR));
    // only the low byte lane enabled: the upper byte keeps its value
    strb_sel = 4'h1;
    wset(ADDR_TENBASE, 32'h0000_ff05);
    strb_sel = 4'hf;
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0805);
    wset(ADDR_TENBASE, 32'h0000_0804);
    rdr(ADDR_TENBASE, rd, rs);
    chk(rd, 32'h0000_0804);
  endtask

  // ==========================================
  // main sequence
  initial begin
    tick(3);
    nrst_i <= 1'b1;
    tick(2);
    t_reset();
    t_tenbase();
    t_polarity();
    t_selftest();
    t_pattern();
    t_unmapped();
    conclude();
  end

endmodule

`default_nettype wire
